/* bms_block_move_sequencer.v */
// execution sequencer for the block move instruction, byte and word count forms
`timescale 1ns/1ps
`include "bms_defs.vh"
module bms_block_move_sequencer (
  // clock and reset
  input  wire        core_clk,
  input  wire        arst_n,
  // instruction fetch stream
  input  wire        codeValid,
  input  wire [7:0]  codeByte,
  input  wire        wordForm,
  // register file values at start
  input  wire [15:0] countWordIn,
  input  wire [15:0] sourcePointerIn,
  input  wire [15:0] destPointerIn,
  input  wire [7:0]  ccrIn,
  // on-chip memory port
  input  wire [7:0]  memReadData,
  output reg  [15:0] memAddr,
  output reg  [7:0]  memWriteData,
  output reg         memRead,
  output reg         memWrite,
  // register results
  output reg  [15:0] countWordReg,
  output reg  [15:0] sourcePointerReg,
  output reg  [15:0] destPointerReg,
  output reg  [7:0]  ccrOut,
  // status
  output reg         busy,
  output reg         done,
  output reg  [15:0] statesUsed
);
  // ************************************************************
  // states
  // ************************************************************
  localparam IDLE  = 3'h0;
  localparam FETCH = 3'h1;
  localparam SETUP = 3'h2;
  localparam TEST  = 3'h3;
  localparam RD    = 3'h4;
  localparam WR    = 3'h5;
  localparam PAD   = 3'h6;
  localparam FIN   = 3'h7;

  reg [2:0]  state;
  reg [2:0]  bytesTaken;
  reg        form;
  reg [2:0]  padCount;
  wire [15:0] stateCount;

  // ************************************************************
  // helpers
  // ************************************************************
  // count of zero depends on form; low byte only for the byte form
  function countIsZero;
    input        f;
    input [15:0] c;
    begin
      countIsZero = (f == `BMS_FORM_WORD) ? (c == 16'h0000) : (c[7:0] == 8'h00);
    end
  endfunction

  // pointers wrap at the top of the 64K space
  function [15:0] stepPointer;
    input [15:0] p;
    begin
      stepPointer = p + 16'h0001;
    end
  endfunction

  // byte form leaves the upper count byte alone
  function [15:0] stepCount;
    input        f;
    input [15:0] c;
    begin
      if (f == `BMS_FORM_WORD) begin
        stepCount = c - 16'h0001;
      end else begin
        stepCount = {c[15:8], c[7:0] - 8'h01};
      end
    end
  endfunction

  // ************************************************************
  // state count
  // ************************************************************
  wire running = (state != IDLE) && (state != FETCH);

  bms_state_counter counter (
    .core_clk   (core_clk),
    .arst_n     (arst_n),
    .startCount (state == SETUP),
    .tick       (running && (state != SETUP)),
    .stateCount (stateCount)
  );

  // ************************************************************
  // memory port
  // ************************************************************
  // memory is registered: read data only stands in the cycle after memRead
  // address holds through WR and PAD so the write lands at the destination
  always @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      memAddr <= 16'h0000;
      memWriteData <= 8'h00;
      memRead <= 1'b0;
      memWrite <= 1'b0;
    end else begin
      memRead <= 1'b0;
      memWrite <= 1'b0;
      case (state)
        TEST: begin
          if (!countIsZero(form, countWordReg)) begin
            memAddr <= sourcePointerReg;
            memRead <= 1'b1;
          end
        end
        RD: begin
          memAddr <= destPointerReg;
        end
        WR: begin
          memWriteData <= memReadData;
          memWrite <= 1'b1;
        end
        default: begin
          memAddr <= memAddr;
        end
      endcase
    end
  end

  // ************************************************************
  // sequencer
  // ************************************************************
  // timing: SETUP, six closing TEST states and FIN make 8
  // each byte costs TEST, RD, WR, PAD = 4 states
  // figures assume single-cycle on-chip memory; there is no wait input, so slower memory cannot stretch them
  always @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      state <= IDLE;
      bytesTaken <= 3'h0;
      form <= `BMS_FORM_BYTE;
      padCount <= 3'h0;
      countWordReg <= 16'h0000;
      sourcePointerReg <= 16'h0000;
      destPointerReg <= 16'h0000;
      ccrOut <= 8'h00;
      busy <= 1'b0;
      done <= 1'b0;
      statesUsed <= 16'h0000;
    end else begin
      done <= 1'b0;
      case (state)
        IDLE: begin
          if (codeValid) begin
            bytesTaken <= 3'h1;
            state <= FETCH;
            busy <= 1'b1;
          end
        end
        FETCH: begin
          if (codeValid) begin
            if (bytesTaken + 3'h1 == `BMS_CODE_BYTES) begin
              state <= SETUP;
            end
            bytesTaken <= bytesTaken + 3'h1;
          end
        end
        SETUP: begin
          form <= wordForm;
          countWordReg <= countWordIn;
          sourcePointerReg <= sourcePointerIn;
          destPointerReg <= destPointerIn;
          ccrOut <= ccrIn; // flags pass through untouched
          padCount <= 3'h0;
          state <= TEST;
        end
        TEST: begin
          if (countIsZero(form, countWordReg)) begin
            padCount <= padCount + 3'h1;
            if (padCount == `BMS_TAIL_LAST) begin
              state <= FIN; // zero count: no transfer
            end
          end else begin
            state <= RD;
          end
        end
        RD: begin
          // source byte arrives in the next cycle
          state <= WR;
        end
        WR: begin
          sourcePointerReg <= stepPointer(sourcePointerReg);
          destPointerReg <= stepPointer(destPointerReg);
          countWordReg <= stepCount(form, countWordReg);
          state <= PAD;
        end
        PAD: begin
          // write lands here; with TEST, RD and WR this keeps four per byte
          padCount <= 3'h0;
          state <= TEST; // repeat until count zero
        end
        FIN: begin
          busy <= 1'b0;
          done <= 1'b1;
          statesUsed <= stateCount + 16'h0001;
          bytesTaken <= 3'h0;
          state <= IDLE;
        end
        default: begin
          state <= IDLE;
        end
      endcase
    end
  end
endmodule

/* bms_defs.vh */
// constants for the block move sequencer
`ifndef BMS_DEFS_VH
`define BMS_DEFS_VH
// ************************************************************
// instruction code
// ************************************************************
`define BMS_CODE_BYTES     3'h4
`define BMS_BASE_STATES    16'h0008
`define BMS_STATES_PER_BYTE 16'h0004
// last index of the six closing TEST states
`define BMS_TAIL_LAST      3'h5
// ************************************************************
// form selection
// ************************************************************
`define BMS_FORM_BYTE      1'b0
`define BMS_FORM_WORD      1'b1
`endif

/* bms_state_counter.v */
// state counter that reports the instruction's total state count
`timescale 1ns/1ps
`include "bms_defs.vh"
module bms_state_counter (
  // clock and reset
  input  wire        core_clk,
  input  wire        arst_n,
  // control
  input  wire        startCount,
  input  wire        tick,
  // result
  output reg  [15:0] stateCount
);
  always @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      stateCount <= 16'h0000;
    end else if (startCount) begin
      stateCount <= 16'h0001;
    end else if (tick) begin
      stateCount <= stateCount + 16'h0001;
    end
  end
endmodule

/* bms_mem_model.sv */
// on-chip memory model answering the sequencer's byte port
`timescale 1ns/1ps
module bms_mem_model (
  // clock
  input  wire        core_clk,
  // byte port
  input  wire [15:0] memAddr,
  input  wire [7:0]  memWriteData,
  input  wire        memRead,
  input  wire        memWrite,
  output reg  [7:0]  memReadData = 8'h00
);
  reg     [7:0] mem [0:65535];
  integer       i;
  initial begin
    for (i = 0; i < 65536; i = i + 1) mem[i] = i[7:0] ^ 8'h5A;
  end
  // data only valid the cycle after a read; otherwise it churns
  always @(posedge core_clk) begin
    if (memRead) memReadData <= mem[memAddr];
    else memReadData <= ~memReadData;
    if (memWrite) mem[memAddr] <= memWriteData;
  end
endmodule

/* bms_chk.sv */
// assertions on the block move sequencer ports
`timescale 1ns/1ps
module bms_chk (
  // clock and reset
  input  wire        core_clk,
  input  wire        arst_n,
  // watched
  input  wire        codeValid,
  input  wire [7:0]  ccrIn,
  input  wire [15:0] memAddr,
  input  wire        memRead,
  input  wire        memWrite,
  input  wire [15:0] countWordReg,
  input  wire [15:0] sourcePointerReg,
  input  wire [15:0] destPointerReg,
  input  wire [7:0]  ccrOut,
  input  wire        busy,
  input  wire        done,
  input  wire [15:0] statesUsed
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!arst_n);
  reg [15:0] rdAddr;
  reg [15:0] wrCnt;
  always @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      rdAddr <= 16'h0000;
      wrCnt  <= 16'h0000;
    end else begin
      if (memRead) rdAddr <= memAddr;
      if (codeValid && !busy) wrCnt <= 16'h0000;
      else if (memWrite) wrCnt <= wrCnt + 16'h0001;
    end
  end
  a_read_source: assert property (memRead |-> memAddr == sourcePointerReg) else $error("read not at source");
  a_write_dest: assert property (memRead |=> (memAddr == destPointerReg) ##1 (memWrite && $stable(memAddr))) else $error("no write");
  a_ptr_step: assert property (memWrite |-> (sourcePointerReg == rdAddr + 16'h0001) && (destPointerReg == memAddr + 16'h0001)) else $error("step");
  a_state_total: assert property (done |-> statesUsed == 16'h0008 + (wrCnt << 2)) else $error("states");
  a_count_zero: assert property (done |-> countWordReg[7:0] == 8'h00) else $error("count left");
  a_done_pulse: assert property (done |=> !done && !busy) else $error("done stuck");
  a_flags_kept: assert property (done |-> ccrOut == ccrIn) else $error("flags changed");
  a_idle_quiet: assert property (!busy |-> !memRead && !memWrite) else $error("idle access");
  a_fetch_first: assert property ($rose(busy) |-> !memRead [*4]) else $error("early read");
endmodule

/* tb_top.sv */
// testbench for the block move sequencer
`timescale 1ns/1ps
module tb_top;
  reg         core_clk = 0, arst_n = 0, codeValid = 0, wordForm = 0;
  reg  [7:0]  codeByte = 8'h00, ccrIn = 8'hA5;
  reg  [15:0] countWordIn = 16'h0000, sourcePointerIn = 16'h0000, destPointerIn = 16'h0000;
  wire [7:0]  memReadData, memWriteData, ccrOut;
  wire [15:0] memAddr, countWordReg, sourcePointerReg, destPointerReg, statesUsed;
  wire        memRead, memWrite, busy, done;
  integer     badCount = 0, checks = 0, k, w, n;
  bms_block_move_sequencer i_dut (.core_clk(core_clk), .arst_n(arst_n), .codeValid(codeValid),
    .codeByte(codeByte), .wordForm(wordForm), .countWordIn(countWordIn), .sourcePointerIn(sourcePointerIn),
    .destPointerIn(destPointerIn), .ccrIn(ccrIn), .memReadData(memReadData), .memAddr(memAddr),
    .memWriteData(memWriteData), .memRead(memRead), .memWrite(memWrite), .countWordReg(countWordReg),
    .sourcePointerReg(sourcePointerReg), .destPointerReg(destPointerReg), .ccrOut(ccrOut),
    .busy(busy), .done(done), .statesUsed(statesUsed));
  bms_mem_model i_mem (.core_clk(core_clk), .memAddr(memAddr), .memWriteData(memWriteData),
    .memRead(memRead), .memWrite(memWrite), .memReadData(memReadData));
  initial forever #25 core_clk = ~core_clk;
  task cmp(input [15:0] seen, input [15:0] exp);
    begin
      checks = checks + 1;
      if (seen !== exp) begin
        badCount = badCount + 1;
        $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
    end
  endtask
  task report_and_stop;
    begin
      if (badCount == 0 && checks > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
    end
  endtask
  // gap inserts idle cycles between code bytes
  task run(input wf, input [15:0] cnt, input [15:0] src, input [15:0] dst, input gap);
    begin
      n = wf ? cnt : cnt[7:0];
      @(posedge core_clk);
      wordForm <= wf;
      countWordIn <= cnt;
      sourcePointerIn <= src;
      destPointerIn <= dst;
      for (k = 0; k < 4; k = k + 1) begin
        codeValid <= 1'b1;
        codeByte <= 8'h7B;
        @(posedge core_clk);
        if (gap) begin
          codeValid <= 1'b0;
          @(posedge core_clk);
        end
      end
      codeValid <= 1'b0;
      // done stands one cycle; look at it settled, on the falling edge
      for (w = 0; w < 2000 && done !== 1'b1; w = w + 1) @(negedge core_clk);
      if (w == 2000) begin
        badCount = badCount + 1;
        report_and_stop;
      end else begin
        cmp(statesUsed, 8 + 4 * n);
        cmp(sourcePointerReg, src + n);
        cmp(destPointerReg, dst + n);
        cmp(countWordReg, wf ? 16'h0000 : {cnt[15:8], 8'h00});
        cmp(ccrOut, ccrIn);
        for (k = 0; k < n; k = k + 1) cmp(i_mem.mem[(dst + k) & 16'hFFFF], ((src + k) ^ 16'h005A) & 16'h00FF);
        if (n == 0) cmp(i_mem.mem[dst], (dst ^ 16'h005A) & 16'h00FF);
      end
    end
  endtask
  task byte_zero_upper; run(1'b0, 16'h0300, 16'h1000, 16'h2000, 1'b0); endtask
  task byte_three_gaps; run(1'b0, 16'h1203, 16'h1100, 16'h2180, 1'b1); endtask
  task word_long; run(1'b1, 16'h0102, 16'h30FF, 16'h4000, 1'b0); endtask
  task word_zero; run(1'b1, 16'h0000, 16'h5000, 16'h6000, 1'b0); endtask
  initial begin
    repeat (10) @(posedge core_clk);
    arst_n <= 1'b1;
    byte_zero_upper;
    byte_three_gaps;
    word_long;
    word_zero;
    report_and_stop;
  end
endmodule
bind bms_block_move_sequencer bms_chk i_chk (.core_clk(core_clk), .arst_n(arst_n), .codeValid(codeValid),
  .ccrIn(ccrIn), .memAddr(memAddr), .memRead(memRead), .memWrite(memWrite), .countWordReg(countWordReg),
  .sourcePointerReg(sourcePointerReg), .destPointerReg(destPointerReg), .ccrOut(ccrOut), .busy(busy),
  .done(done), .statesUsed(statesUsed));
